// ### pvc_regs.sv
// Vendor control and status register bank of a 10/100 transceiver.
// Assumes a classic Wishbone master on clk, event strobes of one
// cycle and status levels synchronous to clk.

`timescale 1ns/10ps

`include "pvc_cfg.svh"

module pvc_regs
    import pvc_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,

    // Wishbone classic slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,

    // Transceiver core events and state
    input  wire pvc_evt_t    evt,
    input  wire pvc_stat_t   stat,

    // Controls to the transceiver core
    output pvc_ctl_t         ctl,

    // Pins
    output logic             irq_pin,
    output logic             status_light_a,
    output logic             status_light_b
);

    // ****************************************************************
    // Storage
    // ****************************************************************

    logic [7:0]  int_en_r;
    logic [7:0]  flag_r;
    logic [7:0]  flag_nxt;
    logic [1:0]  led_mode_r;
    logic        rloop_r;
    logic        altx_r;
    logic        msel_r;
    logic        psd_r;
    logic        force_r;
    logic        psave_r;
    logic        ilvl_r;
    logic        jaben_r;

    logic        req;
    logic        wr_lo;
    logic        wr_hi;
    logic        rd_int;
    logic [5:0]  idx;
    logic [15:0] rd_data;
    logic [7:0]  evt_vec;
    logic        irq_any;

    logic        ctl_altx_r;
    logic        ctl_auto_r;
    logic        ctl_swap_r;
    logic        ctl_loop_r;
    logic        ctl_force_r;
    logic        ctl_rxc_r;
    logic        ctl_jab_r;

    // ****************************************************************
    // Bus decode
    // ****************************************************************

    // One access per ack; the ack cycle itself takes nothing new
    assign req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign idx   = wb_adr_i[7:2];
    assign wr_lo = req & wb_we_i & wb_sel_i[0];
    assign wr_hi = req & wb_we_i & wb_sel_i[1];
    assign rd_int = req & ~wb_we_i & (idx == `PVC_IDX_INT);

    always_ff @(posedge clk) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= req;
        end
    end

    // ****************************************************************
    // Read data
    // ****************************************************************

    always_comb begin
        rd_data = 16'h0000;
        case (idx)
            `PVC_IDX_INT: begin
                rd_data = {int_en_r, flag_r};
            end
            `PVC_IDX_CTL1: begin
                rd_data[`PVC_C1_LED_LSB +: 2] = led_mode_r;
                rd_data[`PVC_C1_POL]    = stat.polarity_rev;
                rd_data[`PVC_C1_XSTATE] = stat.crossover;
                rd_data[`PVC_C1_RLOOP]  = rloop_r;
            end
            `PVC_IDX_CTL2: begin
                rd_data[`PVC_C2_ALTX]   = altx_r;
                rd_data[`PVC_C2_MSEL]   = msel_r;
                rd_data[`PVC_C2_PSD]    = psd_r;
                rd_data[`PVC_C2_ENERGY] = stat.energy;
                rd_data[`PVC_C2_FORCE]  = force_r;
                rd_data[`PVC_C2_PSAVE]  = psave_r;
                rd_data[`PVC_C2_ILVL]   = ilvl_r;
                rd_data[`PVC_C2_JABEN]  = jaben_r;
                rd_data[`PVC_C2_ANDONE] = stat.an_done;
                rd_data[`PVC_C2_FLOW]   = stat.flow_ctrl;
                rd_data[`PVC_C2_ISO]    = stat.isolate;
                rd_data[`PVC_C2_OPM_LSB +: 3] = stat.op_mode;
            end
            default: begin
                rd_data = 16'h0000;
            end
        endcase
    end

    // Unmapped indices answer with zero and swallow writes
    always_ff @(posedge clk) begin
        if (rst) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (req & ~wb_we_i) begin
            wb_dat_o <= {16'h0000, rd_data};
        end
    end

    // ****************************************************************
    // Interrupt enables
    // ****************************************************************

    always_ff @(posedge clk) begin
        if (rst) begin
            int_en_r <= `PVC_RST_INT_EN;
        end else if (wr_hi && idx == `PVC_IDX_INT) begin
            int_en_r <= wb_dat_i[`PVC_INT_EN_LSB +: 8];
        end
    end

    // ****************************************************************
    // Event flags
    // ****************************************************************

    assign evt_vec = evt;

    // An event in the read cycle is not in the returned word,
    // so it must survive the clear
    generate
        for (genvar i = 0; i < 8; i++) begin : g_flag
            assign flag_nxt[i] = (flag_r[i] & ~rd_int) | evt_vec[i];
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (rst) begin
            flag_r <= `PVC_RST_FLAGS;
        end else begin
            flag_r <= flag_nxt;
        end
    end

    // ****************************************************************
    // Interrupt pin
    // ****************************************************************

    assign irq_any = |(flag_r & int_en_r);

    // Pin follows the flags one cycle later; idle high at reset
    always_ff @(posedge clk) begin
        if (rst) begin
            irq_pin <= 1'b1;
        end else begin
            irq_pin <= ilvl_r ? irq_any : ~irq_any;
        end
    end

    // ****************************************************************
    // Control register one
    // ****************************************************************

    always_ff @(posedge clk) begin
        if (rst) begin
            led_mode_r <= `PVC_RST_LED;
        end else if (wr_hi && idx == `PVC_IDX_CTL1) begin
            led_mode_r <= wb_dat_i[`PVC_C1_LED_LSB +: 2];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rloop_r <= 1'b0;
        end else if (wr_lo && idx == `PVC_IDX_CTL1) begin
            rloop_r <= wb_dat_i[`PVC_C1_RLOOP];
        end
    end

    // ****************************************************************
    // Control register two
    // ****************************************************************

    // Pair handling fields
    always_ff @(posedge clk) begin
        if (rst) begin
            altx_r  <= `PVC_RST_ALTX;
            msel_r  <= 1'b0;
            psd_r   <= 1'b0;
        end else if (wr_hi && idx == `PVC_IDX_CTL2) begin
            altx_r  <= wb_dat_i[`PVC_C2_ALTX];
            msel_r  <= wb_dat_i[`PVC_C2_MSEL];
            psd_r   <= wb_dat_i[`PVC_C2_PSD];
        end
    end

    // Link, power, pin and jabber fields
    always_ff @(posedge clk) begin
        if (rst) begin
            force_r <= 1'b0;
            psave_r <= 1'b0;
            ilvl_r  <= 1'b0;
            jaben_r <= `PVC_RST_JABEN;
        end else if (wr_hi && idx == `PVC_IDX_CTL2) begin
            force_r <= wb_dat_i[`PVC_C2_FORCE];
            psave_r <= wb_dat_i[`PVC_C2_PSAVE];
            ilvl_r  <= wb_dat_i[`PVC_C2_ILVL];
            jaben_r <= wb_dat_i[`PVC_C2_JABEN];
        end
    end

    // ****************************************************************
    // Controls to the core
    // ****************************************************************

    // One flop per control, gathered into the struct below; each control keeps
    // its own process except remote loop and force link, which share one, and the struct has a single driver
    always_ff @(posedge clk) begin
        if (rst) begin
            ctl_altx_r <= `PVC_RST_ALTX;
        end else begin
            ctl_altx_r <= altx_r;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ctl_auto_r <= 1'b1;
        end else begin
            ctl_auto_r <= ~psd_r;
        end
    end

    // Auto mode passes the resolved pair state through unchanged
    always_ff @(posedge clk) begin
        if (rst) begin
            ctl_swap_r <= 1'b0;
        end else begin
            ctl_swap_r <= psd_r ? msel_r : stat.crossover;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ctl_loop_r  <= 1'b0;
            ctl_force_r <= 1'b0;
        end else begin
            ctl_loop_r  <= rloop_r;
            ctl_force_r <= force_r;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ctl_jab_r <= `PVC_RST_JABEN;
        end else begin
            ctl_jab_r <= jaben_r;
        end
    end

    // Receive clock stays off until a link is up again, not just
    // until the cable returns, so the MAC never sees a half-trained clock
    always_ff @(posedge clk) begin
        if (rst) begin
            ctl_rxc_r <= 1'b1;
        end else if (!psave_r) begin
            ctl_rxc_r <= 1'b1;
        end else if (!stat.cable_on) begin
            ctl_rxc_r <= 1'b0;
        end else if (stat.link_ok) begin
            ctl_rxc_r <= 1'b1;
        end
    end

    assign ctl = {ctl_altx_r, ctl_auto_r, ctl_swap_r, ctl_loop_r, ctl_force_r, ctl_rxc_r, ctl_jab_r};

    // ****************************************************************
    // Status lights
    // ****************************************************************

    // Reserved modes leave both lights dark
    always_ff @(posedge clk) begin
        if (rst) begin
            status_light_a <= 1'b0;
            status_light_b <= 1'b0;
        end else begin
            case (led_mode_r)
                `PVC_LED_SPEED: begin
                    status_light_b <= stat.speed100;
                    status_light_a <= stat.link_ok & ~stat.activity;
                end
                `PVC_LED_ACT: begin
                    status_light_b <= stat.activity;
                    status_light_a <= stat.link_ok;
                end
                default: begin
                    status_light_b <= 1'b0;
                    status_light_a <= 1'b0;
                end
            endcase
        end
    end

endmodule : pvc_regs

// ### pvc_cfg.svh
// Constants of the transceiver vendor register bank.
// Assumes inclusion by bare name from the bank module and its checker.
`ifndef PVC_CFG_SVH
`define PVC_CFG_SVH

// Register indices; byte address is four times the index
`define PVC_IDX_INT       6'h1B
`define PVC_IDX_CTL1      6'h1E
`define PVC_IDX_CTL2      6'h1F

// Field positions of the interrupt register
`define PVC_INT_EN_LSB    8
`define PVC_INT_FLAG_LSB  0

// Field positions of control register one
`define PVC_C1_LED_LSB    14
`define PVC_C1_POL        13
`define PVC_C1_XSTATE     11
`define PVC_C1_RLOOP      7

// Field positions of control register two
`define PVC_C2_ALTX       15
`define PVC_C2_MSEL       14
`define PVC_C2_PSD        13
`define PVC_C2_ENERGY     12
`define PVC_C2_FORCE      11
`define PVC_C2_PSAVE      10
`define PVC_C2_ILVL       9
`define PVC_C2_JABEN      8
`define PVC_C2_ANDONE     7
`define PVC_C2_FLOW       6
`define PVC_C2_ISO        5
`define PVC_C2_OPM_LSB    2

// Reset values
`define PVC_RST_INT_EN    8'h00
`define PVC_RST_FLAGS     8'h00
`define PVC_RST_LED       2'h0
`define PVC_RST_ALTX      1'b1
`define PVC_RST_JABEN     1'b1

// Light modes
`define PVC_LED_SPEED     2'h0
`define PVC_LED_ACT       2'h1

`endif

// ### pvc_pkg.sv
// Types shared by the vendor register bank and its surroundings.
// Assumes pvc_cfg.svh is on the include path.
package pvc_pkg;

    // Event strobes, bit order matches the flag field (7 down to 0)
    typedef struct packed {
        logic jabber;
        logic rx_error;
        logic page_rx;
        logic pd_fault;
        logic lp_ack;
        logic link_down;
        logic remote_fault;
        logic link_up;
    } pvc_evt_t;

    // Live state reported by the transceiver core
    typedef struct packed {
        logic       polarity_rev;
        logic       crossover;
        logic       energy;
        logic       an_done;
        logic       flow_ctrl;
        logic       isolate;
        logic [2:0] op_mode;
        logic       cable_on;
        logic       link_ok;
        logic       speed100;
        logic       activity;
    } pvc_stat_t;

    // Controls driven into the transceiver core
    typedef struct packed {
        logic alt_auto_crossover_select;
        logic auto_xover_en;
        logic pair_swap;
        logic remote_loop;
        logic force_link;
        logic rxc_en;
        logic jabber_cnt_en;
    } pvc_ctl_t;

endpackage : pvc_pkg

// ### pvc_regs_checker.sv
// Assertions on the ports of the vendor register bank.
// Assumes a bind to pvc_regs and a one-cycle registered ack.
`timescale 1ns/10ps
`include "pvc_cfg.svh"
module pvc_regs_checker
    import pvc_pkg::*;
(
    // Bus
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    // Core side and pins
    input wire pvc_evt_t    evt,
    input wire pvc_stat_t   stat,
    input wire pvc_ctl_t    ctl,
    input wire logic        irq_pin,
    input wire logic        status_light_a,
    input wire logic        status_light_b
);
    // ************
    // Shadow state
    // ************
    logic       tk;
    logic       wr;
    logic       rd_int;
    logic [7:0] en_r;
    logic [7:0] c2_r;
    logic       rl_r;
    logic       clean_r;
    assign tk     = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr     = tk && wb_we_i;
    assign rd_int = tk && !wb_we_i && wb_adr_i[7:2] == `PVC_IDX_INT;

    // Writable bits only; read-only bits are taken from stat
    always_ff @(posedge clk) begin
        if (rst) begin
            en_r <= 8'h00;
            c2_r <= 8'h81;
            rl_r <= 1'h0;
        end else if (wr) begin
            if (wb_sel_i[1] && wb_adr_i[7:2] == `PVC_IDX_INT)
                en_r <= wb_dat_i[15:8];
            if (wb_sel_i[1] && wb_adr_i[7:2] == `PVC_IDX_CTL2)
                c2_r <= wb_dat_i[15:8] & 8'hEF;
            if (wb_sel_i[0] && wb_adr_i[7:2] == `PVC_IDX_CTL1)
                rl_r <= wb_dat_i[7];
        end
    end

    // Flags known empty: read seen, no event since; unknown after reset
    always_ff @(posedge clk) begin
        if (rst || evt != 8'h00)
            clean_r <= 1'b0;
        else if (rd_int)
            clean_r <= 1'b1;
    end

    // **********
    // Properties
    // **********
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    a_ack_one_pulse: assert property (tk |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack is not one cycle after a take");
    a_flag_records: assert property ((evt != 8'h00) ##1 rd_int |=>
        (wb_dat_o[7:0] & $past(evt, 2)) == $past(evt, 2)) else $error("event flag missing");
    a_read_clears: assert property (rd_int && clean_r |=> wb_dat_o[7:0] == 8'h00)
        else $error("flag survived a read");
    a_irq_idle_level: assert property (clean_r && $past(clean_r) && $stable(c2_r) |->
        irq_pin == !c2_r[1]) else $error("interrupt pin not idle");
    a_irq_enabled_event: assert property (((evt & en_r) != 8'h00) && !wr ##1 !wr |=>
        irq_pin == c2_r[1]) else $error("enabled event gave no interrupt");
    a_ctl_follows: assert property ($stable(c2_r) && $stable(rl_r) && !$past(rst) |->
        {ctl.alt_auto_crossover_select, ctl.auto_xover_en, ctl.force_link, ctl.jabber_cnt_en, ctl.remote_loop}
        == {c2_r[7], !c2_r[5], c2_r[3], c2_r[0], rl_r}) else $error("control output wrong");
    a_pair_select: assert property ($stable(c2_r) && !$past(rst) |->
        ctl.pair_swap == (c2_r[5] ? c2_r[6] : $past(stat.crossover))) else $error("pair swap wrong");
    a_rxc_gate: assert property ($stable(c2_r) && (!c2_r[2] || !stat.cable_on) |=>
        ctl.rxc_en == !$past(c2_r[2])) else $error("receive clock gate wrong");
    a_status_ro: assert property (tk && !wb_we_i && wb_adr_i[7:2] == `PVC_IDX_CTL2 |=>
        {wb_dat_o[12], wb_dat_o[7:2]} == {$past(stat.energy), $past(stat.an_done), $past(stat.flow_ctrl),
        $past(stat.isolate), $past(stat.op_mode)}) else $error("status bits wrong");

    c_read_clean: cover property (rd_int && clean_r);
    c_irq_active: cover property (irq_pin && c2_r[1]);
    c_rxc_stopped: cover property (c2_r[2] && !ctl.rxc_en);
endmodule : pvc_regs_checker

bind pvc_regs pvc_regs_checker u_chk (.clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .evt(evt), .stat(stat), .ctl(ctl), .irq_pin(irq_pin),
    .status_light_a(status_light_a), .status_light_b(status_light_b));

// ### testbench.sv
// Self-checking bench for the vendor register bank.
// Drives the Wishbone port, event strobes and core status itself.
`timescale 1ns/10ps
module testbench
    import pvc_pkg::*;
;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        req = 1'b0;
    logic        we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [31:0] q;
    logic [31:0] rdat;
    logic        ack;
    logic        irq;
    logic        la;
    logic        lb;
    logic [1:0]  lexp;
    pvc_evt_t    evt = '0;
    pvc_stat_t   stat = '0;
    pvc_ctl_t    ctl;
    int          failures = 0;
    int          n_checks = 0;

    always #10 clk = ~clk;

    pvc_regs dut (.clk(clk), .rst(rst), .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .evt(evt), .stat(stat),
        .ctl(ctl), .irq_pin(irq), .status_light_a(la), .status_light_b(lb));

    // ***************
    // Bus and compare
    // ***************
    task automatic end_sim();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : end_sim

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // Request held until ack is sampled high, then one idle cycle
    task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d);
        int   n;
        logic got;
        n = 0;
        req  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= {16'h0000, d};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = rdat;
        got = ack;
        req <= 1'b0;
        @(posedge clk);
        if (got !== 1'b1) begin
            chk("ack", 32'h1, {31'h0, got});
            end_sim();
        end
    endtask : acc

    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
        acc(1'b0, a, 16'h0000);
        chk(nm, e, q);
    endtask : rdc

    task automatic pulse(input logic [7:0] e);
        evt <= pvc_evt_t'(e);
        @(posedge clk);
        evt <= '0;
        repeat (2) @(posedge clk);
    endtask : pulse

    // *****
    // Tests
    // *****
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        // Polarity, crossover, energy, negotiated, isolate, mode 6, cable, link, 100M, idle
        stat <= pvc_stat_t'(13'h1EEE);
        repeat (2) @(posedge clk);
        rdc("int_rst", 8'h6C, 32'h0000);
        rdc("c1_rst", 8'h78, 32'h2800);
        rdc("c2_rst", 8'h7C, 32'h91B8);
        for (int m = 0; m < 8; m++) begin
            stat.op_mode <= m[2:0];
            acc(1'b0, 8'h7C, 16'h0000);
            chk("op_mode", 32'(m), {29'h0, q[4:2]});
        end
        acc(1'b1, 8'h00, 16'hFFFF);
        rdc("unmapped", 8'h00, 32'h0);
        acc(1'b1, 8'h7C, 16'hFFFF);
        acc(1'b1, 8'h78, 16'hFFFF);
        rdc("c2_wr", 8'h7C, 32'hFFBC);
        rdc("c1_wr", 8'h78, 32'hE880);
        chk("ctl_on", 32'h5F, {25'h0, ctl});
        stat.cable_on <= 1'b0;
        repeat (2) @(posedge clk);
        chk("rxc_unplug", 32'h0, {31'h0, ctl.rxc_en});
        stat.cable_on <= 1'b1;
        stat.link_ok  <= 1'b0;
        repeat (2) @(posedge clk);
        chk("rxc_nolink", 32'h0, {31'h0, ctl.rxc_en});
        stat.link_ok <= 1'b1;
        repeat (2) @(posedge clk);
        chk("rxc_link", 32'h1, {31'h0, ctl.rxc_en});
        $display("test registers done");
        acc(1'b1, 8'h6C, 16'hFFFF);
        for (int i = 0; i < 8; i++) begin
            pulse(8'h01 << i);
            chk("irq_on", 32'h1, {31'h0, irq});
            rdc("flag", 8'h6C, 32'hFF00 | (32'h1 << i));
            chk("irq_off", 32'h0, {31'h0, irq});
            rdc("flag_clr", 8'h6C, 32'hFF00);
        end
        acc(1'b1, 8'h7C, 16'h0000);
        chk("ctl_off", 32'h3A, {25'h0, ctl});
        acc(1'b1, 8'h6C, 16'h0000);
        pulse(8'h81);
        chk("irq_mask", 32'h1, {31'h0, irq});
        rdc("flag_mask", 8'h6C, 32'h0081);
        acc(1'b1, 8'h6C, 16'h8000);
        pulse(8'h80);
        chk("irq_low", 32'h0, {31'h0, irq});
        rdc("flag_low", 8'h6C, 32'h8080);
        chk("irq_low_off", 32'h1, {31'h0, irq});
        $display("test interrupts done");
        // Event just before a read is returned; one in the read cycle is kept
        evt <= pvc_evt_t'(8'h42);
        @(posedge clk);
        evt <= '0;
        rdc("flag_next", 8'h6C, 32'h8042);
        evt <= pvc_evt_t'(8'h10);
        fork
            begin
                @(posedge clk);
                evt <= '0;
            end
        join_none
        rdc("flag_race", 8'h6C, 32'h8000);
        rdc("flag_kept", 8'h6C, 32'h8010);
        $display("test flag timing done");
        // Link up, no activity, 100M: modes 0 and 1 show distinct pairs, modes 2 and 3 are both dark
        for (int m = 0; m < 4; m++) begin
            acc(1'b1, 8'h78, {m[1:0], 14'h0000});
            lexp = (m == 0) ? 2'h3 : (m == 1) ? 2'h2 : 2'h0;
            chk("lights", {30'h0, lexp}, {30'h0, la, lb});
        end
        stat.activity <= 1'b1;
        for (int m = 0; m < 2; m++) begin
            acc(1'b1, 8'h78, {m[1:0], 14'h0000});
            chk("lights_act", (m == 0) ? 32'h1 : 32'h3, {30'h0, la, lb});
        end
        chk("rloop_off", 32'h0, {31'h0, ctl.remote_loop});
        $display("test lights done");
        end_sim();
    end
endmodule : testbench
